//--- core/fwx_ctrl.sv
// module: host controller for a width and depth expanded fifo bank
`timescale 1ns/1ns
// Function
// - same write/read controls to every bank device
// - side by side devices form wide word
// - almost flags taken from one device
// - read enable may be tied asserted
// - load pin low in reset selects programming
// - exactly one device marked first loader
// - all other devices have first select high
// - cascade token outputs form a ring
// - depth composite flags OR every device flag
// - width composite empty and full flags
module fwx_ctrl #(
    parameter int WIDTH_DEV = fwx_pkg::NUM_WIDTH_DEV,
    parameter int DEPTH_DEV = fwx_pkg::NUM_DEPTH_DEV
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // user write side
    input wire logic wr_valid,
    input wire logic [WIDTH_DEV*fwx_pkg::DEV_WIDTH-1:0] wr_data,
    output logic wr_ready,
    // user read side
    input wire logic rd_req,
    output logic rd_ready,
    input wire logic [WIDTH_DEV*fwx_pkg::DEV_WIDTH-1:0] dev_q,
    output logic [WIDTH_DEV*fwx_pkg::DEV_WIDTH-1:0] rd_data,
    output logic rd_data_valid,
    // user configuration
    input wire logic prog_mode,
    input wire logic ofs_wr,
    input wire logic [fwx_pkg::DEV_WIDTH-1:0] ofs_data,
    input wire logic bank_reset,
    output logic [1:0] ofs_index,
    output logic busy,
    // device control pins, shared by all devices
    output logic dev_reset_n,
    output logic dev_wen_n,
    output logic dev_ren_n,
    output logic offset_load_select_n,
    output logic [WIDTH_DEV*fwx_pkg::DEV_WIDTH-1:0] dev_d,
    // depth cascade pins
    output logic [DEPTH_DEV-1:0] first_device_select_n,
    input wire logic [DEPTH_DEV-1:0] cascade_token_out_n,
    output logic [DEPTH_DEV-1:0] cascade_token_in_n,
    // device flags, active low; empty and full one per device in bank, almost flags single
    input wire logic [WIDTH_DEV*DEPTH_DEV-1:0] empty_flag_n,
    input wire logic [WIDTH_DEV*DEPTH_DEV-1:0] full_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n,
    // composite status
    output logic bank_empty,
    output logic bank_full,
    output logic bank_almost_empty,
    output logic bank_almost_full
);
    initial begin
        if (WIDTH_DEV < 1 || DEPTH_DEV < 1) begin
            $error("bank needs at least one device each way");
        end
    end

    fwx_pkg::fwx_state_t state_ff;
    logic [3:0] rst_cnt_ff;
    logic [1:0] ofs_idx_ff;
    logic comp_empty_ff;
    logic comp_full_ff;
    logic do_wr;
    logic do_rd;
    logic do_ofs;
    logic ren_q_ff;

    // first device strap fixed: device 0 loads first, the rest high
    always_comb begin
        first_device_select_n = '1;
        first_device_select_n[0] = 1'b0;
    end

    // token ring: each output feeds the next input, last wraps to first
    always_comb begin
        for (int i = 0; i < DEPTH_DEV; i++) begin
            cascade_token_in_n[i] = cascade_token_out_n[(i + DEPTH_DEV - 1) % DEPTH_DEV];
        end
    end

    // composite flags, registered: any device at a boundary stops traffic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            comp_empty_ff <= 1'b1;
            comp_full_ff <= 1'b1;
        end else begin
            comp_empty_ff <= |(~empty_flag_n);
            comp_full_ff <= |(~full_flag_n);
        end
    end
    assign bank_empty = comp_empty_ff;
    assign bank_full = comp_full_ff;
    // partial flags from device 0 alone
    assign bank_almost_empty = ~almost_empty_flag_n;
    assign bank_almost_full = ~almost_full_flag_n;

    // state: reset pulse with load strap, then run or program
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= fwx_pkg::FWX_RESET;
            rst_cnt_ff <= 4'h0;
        end else begin
            case (state_ff)
                fwx_pkg::FWX_RESET: begin
                    if (rst_cnt_ff >= fwx_pkg::RESET_CNT) begin
                        state_ff <= prog_mode ? fwx_pkg::FWX_PROG : fwx_pkg::FWX_RUN;
                    end else begin
                        rst_cnt_ff <= rst_cnt_ff + 4'h1;
                    end
                end
                fwx_pkg::FWX_RUN: begin
                    if (bank_reset) begin
                        state_ff <= fwx_pkg::FWX_RESET;
                        rst_cnt_ff <= 4'h0;
                    end else if (prog_mode) begin
                        state_ff <= fwx_pkg::FWX_PROG;
                    end
                end
                fwx_pkg::FWX_PROG: begin
                    if (bank_reset) begin
                        state_ff <= fwx_pkg::FWX_RESET;
                        rst_cnt_ff <= 4'h0;
                    end else if (!prog_mode) begin
                        state_ff <= fwx_pkg::FWX_RUN;
                    end
                end
                default: begin
                    state_ff <= fwx_pkg::FWX_RESET;
                    rst_cnt_ff <= 4'h0;
                end
            endcase
        end
    end
    assign busy = (state_ff == fwx_pkg::FWX_RESET);

    // read and write qualifiers gated by composite status; offset write by prog state only
    assign wr_ready = (state_ff == fwx_pkg::FWX_RUN) && !comp_full_ff;
    assign rd_ready = (state_ff == fwx_pkg::FWX_RUN) && !comp_empty_ff;
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_req && rd_ready;
    assign do_ofs = (state_ff == fwx_pkg::FWX_PROG) && ofs_wr;

    // shared device pins, registered; load low held across reset for prog
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_reset_n <= 1'b0;
            dev_wen_n <= 1'b1;
            dev_ren_n <= 1'b1;
            offset_load_select_n <= 1'b1;
            dev_d <= '0;
        end else begin
            dev_reset_n <= (state_ff != fwx_pkg::FWX_RESET);
            offset_load_select_n <= !((state_ff == fwx_pkg::FWX_RESET && prog_mode)
                                      || state_ff == fwx_pkg::FWX_PROG);
            dev_wen_n <= !(do_wr || do_ofs);
            dev_ren_n <= !do_rd;
            if (do_ofs) begin
                dev_d <= {WIDTH_DEV{ofs_data}}; // offset reaches every lane
            end else if (do_wr) begin
                dev_d <= wr_data;
            end
        end
    end

    // offset register pointer mirrors device sequencing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_idx_ff <= fwx_pkg::OFS_EMPTY_LO;
        end else if (state_ff == fwx_pkg::FWX_RESET) begin
            ofs_idx_ff <= fwx_pkg::OFS_EMPTY_LO;
        end else if (do_ofs) begin
            ofs_idx_ff <= (ofs_idx_ff == fwx_pkg::OFS_FULL_HI) ?
                          fwx_pkg::OFS_EMPTY_LO : ofs_idx_ff + 2'h1;
        end
    end
    assign ofs_index = ofs_idx_ff;

    // read data taken the cycle after the device saw its read strobe,
    // since the device drives its outputs only after that clock edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ren_q_ff <= 1'b0;
            rd_data <= '0;
            rd_data_valid <= 1'b0;
        end else begin
            ren_q_ff <= !dev_ren_n;
            rd_data_valid <= ren_q_ff;
            if (ren_q_ff) begin
                rd_data <= dev_q;
            end
        end
    end

    // exactly one first loader in the cascade
    a_first_one_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $countones(~first_device_select_n) == 1) else $error("first select count");

    // every other device strapped high
    a_others_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        &first_device_select_n[DEPTH_DEV-1:1] || DEPTH_DEV == 1) else $error("others low");

    // last token output returns to the first input
    a_ring_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cascade_token_in_n[0] == cascade_token_out_n[DEPTH_DEV-1]) else $error("ring");

    // composite empty clears once no device is empty
    a_empty_comp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (&empty_flag_n) |=> !bank_empty) else $error("empty comp");

    // any full device sets the composite full
    a_full_comp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(&full_flag_n) |=> bank_full) else $error("full comp");

    // no write strobe while the bank is full in the run state
    a_no_wr_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bank_full && state_ff == fwx_pkg::FWX_RUN) |=> dev_wen_n) else $error("wr full");

    // no read strobe while the bank is empty
    a_no_rd_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bank_empty |=> dev_ren_n) else $error("rd empty");

    // offset pointer wraps after the fourth register
    a_ofs_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (do_ofs && ofs_idx_ff == fwx_pkg::OFS_FULL_HI && !bank_reset)
        |=> ofs_idx_ff == fwx_pkg::OFS_EMPTY_LO) else $error("ofs wrap");

    // load pin low while programming
    a_load_in_prog: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == fwx_pkg::FWX_PROG) |=> !offset_load_select_n) else $error("load");

    // accepted write strobes the whole bank once
    a_wr_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_wr |=> !dev_wen_n) else $error("write strobe missing");

    // no write strobe without a request
    a_wen_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(do_wr || do_ofs) |=> dev_wen_n) else $error("stray write strobe");

    // accepted read strobes the whole bank once
    a_rd_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_rd |=> !dev_ren_n) else $error("read strobe missing");

    // no read strobe without a request
    a_ren_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !do_rd |=> dev_ren_n) else $error("stray read strobe");

    // no strobes during the device reset pulse
    a_reset_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == fwx_pkg::FWX_RESET) |=> dev_wen_n && dev_ren_n) else $error("strobe in reset");

    // wide word reaches all lanes together
    a_wr_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_wr |=> dev_d == $past(wr_data)) else $error("write word");

    // device read answered two cycles later
    a_rd_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !dev_ren_n |-> ##2 rd_data_valid) else $error("read valid late");

    // read word is what the devices drove
    a_rd_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ren_q_ff |=> rd_data == $past(dev_q)) else $error("read word");

    // valid only follows a device read
    a_valid_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_data_valid |-> $past(ren_q_ff)) else $error("stray read valid");

    // offset pointer steps by one
    a_ofs_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (do_ofs && ofs_idx_ff != fwx_pkg::OFS_FULL_HI && !bank_reset)
        |=> ofs_idx_ff == $past(ofs_idx_ff) + 2'h1) else $error("ofs step");

    // offset write drives data and strobe
    a_ofs_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_ofs |=> !dev_wen_n && dev_d[8:0] == $past(ofs_data)) else $error("ofs data");

    // device reset pin low in reset state
    a_reset_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == fwx_pkg::FWX_RESET) |=> !dev_reset_n) else $error("reset pin");

    // load strap held low across reset for programming
    a_load_strap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == fwx_pkg::FWX_RESET && prog_mode) |=> !offset_load_select_n)
        else $error("load strap");

    // load pin high in normal running
    a_run_load_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == fwx_pkg::FWX_RUN) |=> offset_load_select_n) else $error("load in run");

    // almost empty passed through from one device
    a_almost_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bank_almost_empty == !almost_empty_flag_n) else $error("almost empty");
endmodule : fwx_ctrl

//--- core/fwx_pkg.sv
// package: constants for the fifo bank expansion controller
package fwx_pkg;
    // bank shape
    localparam int DEV_WIDTH = 9;
    localparam int NUM_WIDTH_DEV = 2;
    localparam int NUM_DEPTH_DEV = 3;
    // offset register sequence
    localparam int OFS_REGS = 4;
    localparam logic [1:0] OFS_EMPTY_LO = 2'h0;
    localparam logic [1:0] OFS_EMPTY_HI = 2'h1;
    localparam logic [1:0] OFS_FULL_LO = 2'h2;
    localparam logic [1:0] OFS_FULL_HI = 2'h3;
    // reset pulse, least time and cycle count at 20 MHz
    localparam int CLK_MHZ = 20;
    localparam int RESET_NS = 25;
    localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] RESET_CNT = 4'(RESET_CYC < 1 ? 1 : RESET_CYC);
    // controller states
    typedef enum logic [1:0] {
        FWX_RESET = 2'b00,
        FWX_RUN = 2'b01,
        FWX_PROG = 2'b10
    } fwx_state_t;
endpackage : fwx_pkg

//--- tb/fwx_bank_model.sv
// model of the sibling fifo devices in the bank
`timescale 1ns/1ns
module fwx_bank_model #(
    parameter int DW = 18,
    parameter int NF = 6,
    parameter int DEPTH = 4
) (
    // control from host
    input wire logic sys_clk,
    input wire logic dev_reset_n,
    input wire logic dev_wen_n,
    input wire logic dev_ren_n,
    input wire logic offset_load_select_n,
    input wire logic [DW-1:0] dev_d,
    // data and flags to host
    output logic [DW-1:0] dev_q,
    output logic [NF-1:0] empty_flag_n,
    output logic [NF-1:0] full_flag_n
);
    logic [DW-1:0] mem[$];
    logic [8:0] ofs_mem[4];
    logic [1:0] ofs_ptr = 2'h0;
    logic prog = 1'b0;
    // storage, offset registers and flags, all moved on the clock edge
    always @(posedge sys_clk) begin
        if (!dev_reset_n) begin
            mem.delete();
            ofs_ptr <= 2'h0;
            prog <= !offset_load_select_n;
        end else begin
            // read first, so a word written on this edge is not yet readable
            if (!dev_ren_n && mem.size() > 0)
                dev_q <= mem.pop_front();
            if (!dev_wen_n && prog && !offset_load_select_n) begin
                ofs_mem[ofs_ptr] <= dev_d[8:0];
                ofs_ptr <= ofs_ptr + 2'h1;
            end else if (!dev_wen_n && mem.size() < DEPTH)
                mem.push_back(dev_d);
        end
        // empty shown by first device, full by last, so composites must use all
        empty_flag_n <= ~NF'(mem.size() == 0);
        full_flag_n <= ~(NF'(mem.size() == DEPTH) << (NF - 1));
    end
endmodule : fwx_bank_model

//--- tb/testbench.sv
// self-checking bench for the fifo bank controller
`timescale 1ns/1ns
module testbench;
    localparam int DW = fwx_pkg::NUM_WIDTH_DEV * fwx_pkg::DEV_WIDTH;
    localparam int D = fwx_pkg::NUM_DEPTH_DEV;
    localparam int NF = fwx_pkg::NUM_WIDTH_DEV * D;
    localparam int DEPTH = 4;
    logic sys_clk = 1'b0, rst_n = 1'b0, wr_valid = 1'b0, rd_req = 1'b0, prog_mode = 1'b0;
    logic ofs_wr = 1'b0, bank_reset = 1'b0, almost_empty_flag_n = 1'b1, almost_full_flag_n = 1'b1;
    logic wr_ready, rd_ready, rd_data_valid, busy, dev_reset_n, dev_wen_n, dev_ren_n;
    logic offset_load_select_n, bank_empty, bank_full, bank_almost_empty, bank_almost_full;
    logic [DW-1:0] wr_data = '0, dev_q, rd_data, dev_d;
    logic [8:0] ofs_data = 9'h000;
    logic [1:0] ofs_index;
    logic [D-1:0] first_device_select_n, cascade_token_out_n = '0, cascade_token_in_n;
    logic [NF-1:0] empty_flag_n, full_flag_n;
    logic [DW-1:0] exp_q[$];
    logic [8:0] ofs_exp[4];
    int num_errors = 0, num_checks = 0;
    // 20 mhz clock
    always #25 sys_clk = ~sys_clk;
    fwx_ctrl fwx_ctrl_i (.*);
    fwx_bank_model #(.DW(DW), .NF(NF), .DEPTH(DEPTH)) fwx_bank_model_i (.*);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // write one word, held until taken
    task put(input logic [DW-1:0] w);
        wr_valid <= 1'b1;
        wr_data <= w;
        do @(negedge sys_clk); while (wr_ready !== 1'b1);
        @(posedge sys_clk);
        exp_q.push_back(w);
    endtask : put
    task get;
        rd_req <= 1'b1;
        do @(negedge sys_clk); while (rd_ready !== 1'b1);
        @(posedge sys_clk);
    endtask : get
    // bounded wait for device reset sequence, ends at a falling edge
    task idle_wait;
        int n;
        n = 0;
        repeat (2) @(negedge sys_clk);
        while (busy !== 1'b0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check(busy, 0);
    endtask : idle_wait
    // each delivered word against the oldest note
    always @(posedge sys_clk) begin
        if (rd_data_valid === 1'b1)
            check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data);
    end
    // hang guard
    initial begin
        #(50 * 5000);
        num_errors++;
        complete_run();
    end
    // main sequence
    initial begin
        void'($urandom(32'hbca4_e1cf));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        idle_wait();
        check(first_device_select_n, {{(D - 1){1'b1}}, 1'b0});
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            cascade_token_out_n <= D'($urandom);
            {almost_empty_flag_n, almost_full_flag_n} <= 2'($urandom);
            @(negedge sys_clk);
            check(cascade_token_in_n, {cascade_token_out_n[D-2:0], cascade_token_out_n[D-1]});
            check({bank_almost_empty, bank_almost_full}, 2'(~{almost_empty_flag_n, almost_full_flag_n}));
            @(posedge sys_clk);
        end
        $display("test wiring done");
        prog_mode <= 1'b1;
        bank_reset <= 1'b1;
        @(posedge sys_clk);
        bank_reset <= 1'b0;
        idle_wait();
        check({fwx_bank_model_i.prog, wr_ready}, 2'h2);
        @(posedge sys_clk);
        ofs_wr <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            logic [8:0] v;
            v = 9'($urandom);
            ofs_data <= v;
            ofs_exp[i % 4] = v;
            @(posedge sys_clk);
        end
        ofs_wr <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check(ofs_index, 1);
        for (int k = 0; k < 4; k++)
            check(fwx_bank_model_i.ofs_mem[k], ofs_exp[k]);
        $display("test offsets done");
        @(posedge sys_clk);
        prog_mode <= 1'b0;
        bank_reset <= 1'b1;
        @(posedge sys_clk);
        bank_reset <= 1'b0;
        idle_wait();
        @(posedge sys_clk);
        for (int i = 0; i < DEPTH; i++)
            put(DW'($urandom));
        wr_valid <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check({bank_full, wr_ready, bank_empty}, 3'h4);
        @(posedge sys_clk);
        for (int i = 0; i < DEPTH; i++)
            get();
        rd_req <= 1'b0;
        repeat (4) @(negedge sys_clk);
        check({bank_empty, rd_ready, exp_q.size() == 0}, 3'h5);
        $display("test fill drain done");
        @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            put(DW'($urandom));
            wr_valid <= 1'b0;
            get();
            rd_req <= 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        check(exp_q.size(), 0);
        $display("test alternate done");
        complete_run();
    end
endmodule : testbench
